// file: src/ecff_map.svh
`ifndef ECFF_MAP_SVH
`define ECFF_MAP_SVH
// byte offsets in the configuration array
`define ECFF_OFS_CMDQ 8'h0F
`define ECFF_OFS_REMOVAL 8'h10
`define ECFF_OFS_PSA 8'h11
`define ECFF_OFS_MAX 8'h12
`define ECFF_OFS_PRE 8'h16
`define ECFF_OFS_FWRES 8'h1A
`define ECFF_OFS_OPC 8'h1D
`define ECFF_OFS_MODE 8'h1E
`define ECFF_OFS_BARRIER 8'h1F
`define ECFF_WIDE_BYTES 8'h04
// mode, operation and result codes
`define ECFF_MODE_NORMAL 8'h00
`define ECFF_MODE_UPDATE 8'h01
`define ECFF_MODE_VENDOR 8'h10
`define ECFF_OP_INSTALL 8'h01
`define ECFF_OP_ABORT 8'h02
`define ECFF_RES_OK 8'h00
`define ECFF_RES_GENERAL 8'h10
`define ECFF_RES_INSTALL 8'h11
`define ECFF_RES_DOWNLOAD 8'h12
`define ECFF_RM_THREE_PASS 2'h2
// bit positions
`define ECFF_EN_BIT 0
`define ECFF_PSA_CAP_MAN 0
`define ECFF_PSA_CAP_AUTO 1
`define ECFF_PSA_EN_BIT 4
`define ECFF_PSA_MODE_BIT 5
`define ECFF_RM_CFG_LSB 4
// reset and default values
`define ECFF_ZERO8 8'h00
`define ECFF_ZERO32 32'h0000_0000
`define ECFF_MAX_PRELOAD_DEF 32'h0001_0000
`define ECFF_PSA_CAPS_DEF 2'h3
`define ECFF_RM_CAPS_DEF 4'hF
`define ECFF_LFSR_SEED 8'h5A
// link clock half period in system clocks, less one (divider counts 0 to this value)
`define ECFF_LNK_HALF 5'h0C
// host register block
`define ECFF_AV_CMD 4'h0
`define ECFF_AV_STATUS 4'h4
`define ECFF_CMD_WDATA_LSB 0
`define ECFF_CMD_ADDR_LSB 8
`define ECFF_CMD_WR_BIT 16
`define ECFF_ST_BUSY 0
`define ECFF_ST_ERR 1
`define ECFF_ST_REFUSED 2
`define ECFF_ST_RDATA_LSB 8
`endif

// file: src/ecff_pkg.sv
package ecff_pkg;
  typedef enum logic [1:0] {
    ECFF_PURGE_IDLE = 2'h0,
    ECFF_PURGE_CHAR = 2'h1,
    ECFF_PURGE_CPL = 2'h3,
    ECFF_PURGE_RAND = 2'h2
  } ecff_purge_type;
  typedef enum logic [1:0] {
    ECFF_HOST_IDLE = 2'h0,
    ECFF_HOST_LAUNCH = 2'h1,
    ECFF_HOST_WAIT = 2'h3,
    ECFF_HOST_DONE = 2'h2
  } ecff_host_type;
endpackage

// file: src/ecff_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface ecff_link_if;
  logic lnk_clk;
  logic req;
  logic wr;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic rsp_tog;
  logic [7:0] rsp_rdata;
  logic rsp_err;
  modport dev (input lnk_clk, input req, input wr, input addr, input wdata,
    output rsp_tog, output rsp_rdata, output rsp_err);
  modport host (output lnk_clk, output req, output wr, output addr,
    output wdata, input rsp_tog, input rsp_rdata, input rsp_err);
endinterface
`default_nettype wire

// file: src/ecff_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "ecff_map.svh"
module ecff_host (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  ecff_link_if.host lnk,
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest
);
  ecff_pkg::ecff_host_type state;
  logic [4:0] div_cnt;
  logic lnk_fall;
  logic [9:0] rsp_s1;
  logic [9:0] rsp_s2;
  logic exp_tog;
  logic cmd_wr;
  logic [7:0] cmd_addr;
  logic [7:0] cmd_wdata;
  logic busy;
  logic dev_err;
  logic refused;
  logic rm_sent;
  logic [7:0] rd_byte;
  logic is_cmd;
  logic take_cmd;
  logic bad_cmd;
  logic [7:0] w_addr;
  logic [7:0] w_data;
  logic w_wr;

  // link clock divider, falls are the launch points
  assign lnk_fall = (div_cnt == `ECFF_LNK_HALF) & lnk.lnk_clk;
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      div_cnt <= 5'h00;
      lnk.lnk_clk <= 1'b0;
    end else if (div_cnt == `ECFF_LNK_HALF) begin
      div_cnt <= 5'h00;
      lnk.lnk_clk <= ~lnk.lnk_clk;
    end else begin
      div_cnt <= div_cnt + 5'h01;
    end
  end

  // response from the device end crosses in two flops
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rsp_s1 <= 10'h000;
      rsp_s2 <= 10'h000;
    end else begin
      rsp_s1 <= {lnk.rsp_tog, lnk.rsp_err, lnk.rsp_rdata};
      rsp_s2 <= rsp_s1;
    end
  end

  // bus accepts in the cycle after waitrequest was seen high
  assign is_cmd = i_avs_address == `ECFF_AV_CMD;
  assign take_cmd = ~o_avs_waitrequest & i_avs_write & is_cmd;
  assign w_addr = i_avs_writedata[`ECFF_CMD_ADDR_LSB +: 8];
  assign w_data = i_avs_writedata[`ECFF_CMD_WDATA_LSB +: 8];
  assign w_wr = i_avs_writedata[`ECFF_CMD_WR_BIT];
  // reserved codes are never sent to the device
  always_comb begin
    bad_cmd = 1'b0;
    if (w_wr && w_addr == `ECFF_OFS_MODE) begin
      bad_cmd = (w_data != `ECFF_MODE_NORMAL) & (w_data != `ECFF_MODE_UPDATE)
        & (w_data != `ECFF_MODE_VENDOR);
    end else if (w_wr && w_addr == `ECFF_OFS_OPC) begin
      bad_cmd = (w_data != `ECFF_OP_INSTALL)
        & (w_data != `ECFF_OP_ABORT);
    end else if (w_wr && w_addr == `ECFF_OFS_REMOVAL) begin
      bad_cmd = rm_sent;
    end else if (w_wr && w_addr == `ECFF_OFS_PSA) begin
      bad_cmd = w_data[7:6] != 2'h0;
    end
  end

  // bus handshake and read data
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata <= `ECFF_ZERO32;
    end else if (!o_avs_waitrequest) begin
      o_avs_waitrequest <= 1'b1;
    end else if ((i_avs_read | i_avs_write) & ~(i_avs_write & is_cmd & busy))
    begin
      o_avs_waitrequest <= 1'b0;
      o_avs_readdata <= `ECFF_ZERO32;
      if (i_avs_read && is_cmd) begin
        o_avs_readdata[`ECFF_CMD_WR_BIT] <= cmd_wr;
        o_avs_readdata[`ECFF_CMD_ADDR_LSB +: 8] <= cmd_addr;
        o_avs_readdata[`ECFF_CMD_WDATA_LSB +: 8] <= cmd_wdata;
      end else if (i_avs_read && i_avs_address == `ECFF_AV_STATUS) begin
        o_avs_readdata[`ECFF_ST_BUSY] <= busy;
        o_avs_readdata[`ECFF_ST_ERR] <= dev_err;
        o_avs_readdata[`ECFF_ST_REFUSED] <= refused;
        o_avs_readdata[`ECFF_ST_RDATA_LSB +: 8] <= rd_byte;
      end
    end
  end

  // one switch access on the link per command
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      state <= ecff_pkg::ECFF_HOST_IDLE;
      busy <= 1'b0;
      cmd_wr <= 1'b0;
      cmd_addr <= `ECFF_ZERO8;
      cmd_wdata <= `ECFF_ZERO8;
      refused <= 1'b0;
      dev_err <= 1'b0;
      rd_byte <= `ECFF_ZERO8;
      exp_tog <= 1'b0;
      rm_sent <= 1'b0;
      lnk.req <= 1'b0;
      lnk.wr <= 1'b0;
      lnk.addr <= `ECFF_ZERO8;
      lnk.wdata <= `ECFF_ZERO8;
    end else begin
      unique case (state)
        ecff_pkg::ECFF_HOST_IDLE: begin
          if (take_cmd) begin
            cmd_wr <= w_wr;
            cmd_addr <= w_addr;
            cmd_wdata <= w_data;
            refused <= bad_cmd;
            if (!bad_cmd) begin
              busy <= 1'b1;
              dev_err <= 1'b0;
              state <= ecff_pkg::ECFF_HOST_LAUNCH;
            end
          end
        end
        ecff_pkg::ECFF_HOST_LAUNCH: begin
          if (lnk_fall) begin
            lnk.req <= 1'b1;
            lnk.wr <= cmd_wr;
            lnk.addr <= cmd_addr;
            lnk.wdata <= cmd_wdata;
            state <= ecff_pkg::ECFF_HOST_WAIT;
          end
        end
        ecff_pkg::ECFF_HOST_WAIT: begin
          if (rsp_s2[9] != exp_tog) begin
            exp_tog <= rsp_s2[9];
            dev_err <= rsp_s2[8];
            rd_byte <= rsp_s2[7:0];
            if (cmd_wr && cmd_addr == `ECFF_OFS_REMOVAL && !rsp_s2[8]) begin
              rm_sent <= 1'b1;
            end
            state <= ecff_pkg::ECFF_HOST_DONE;
          end
        end
        ecff_pkg::ECFF_HOST_DONE: begin
          if (lnk_fall) begin
            lnk.req <= 1'b0;
            busy <= 1'b0;
            state <= ecff_pkg::ECFF_HOST_IDLE;
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// file: src/ecff_device.sv
// Behaviour
// - barrier enable bit writable, reads back
// - mode codes normal, update, vendor only
// - install or abort codes in update mode
// - update result codes reported in status
// - host programs preload sector count
// - oversize preload flags error, value kept
// - maximum preload fixed by vendor, read-only
// - replay partition frame counts one sector
// - manual and auto capability bits read-only
// - enabling unsupported awareness mode gives error
// - bit4 enables awareness, bit5 selects auto
// - mode bit ignored while disabled
// - awareness enable settable only once
// - supported removal methods read-only bits 3:0
// - removal method configured once, bits 5:4
// - method two: char, complement, random
// - command queue enable bit zero
// - host empties queue before disabling
// - queue off behaves as legacy device
`timescale 1ns/1ps
`default_nettype none
`include "ecff_map.svh"
module ecff_device #(
  parameter logic [31:0] MAX_PRELOAD = `ECFF_MAX_PRELOAD_DEF,
  parameter logic [1:0] PSA_CAPS = `ECFF_PSA_CAPS_DEF,
  parameter logic [3:0] RM_CAPS = `ECFF_RM_CAPS_DEF
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  ecff_link_if.dev lnk,
  input wire logic [7:0] i_fw_result,
  input wire logic i_fw_result_vld,
  input wire logic i_purge_start,
  input wire logic [7:0] i_purge_char,
  output logic o_barrier_en,
  output logic o_cmdq_en,
  output logic o_upd_mode,
  output logic o_vendor_mode,
  output logic o_fw_install,
  output logic o_fw_abort,
  output logic o_psa_en,
  output logic o_psa_auto,
  output logic [1:0] o_removal_method,
  output logic o_purge_vld,
  output logic [7:0] o_purge_data,
  output logic o_switch_err
);
  logic [18:0] lnk_s1, lnk_s2;
  logic clk_d, s_clk, s_req, s_wr, rise, served, acc, do_wr, wr_ok;
  logic wr_err, psa_bad, psa_mode, psa_once, rm_once;
  logic [7:0] s_addr, s_wdata, rd_byte, pre_idx, max_idx;
  logic [7:0] mode_sel, op_code, fw_result, lfsr;
  logic [31:0] pre_new, preload;
  ecff_pkg::ecff_purge_type purge;
  // all link pins cross in two flops before use
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      lnk_s1 <= 19'h00000;
      lnk_s2 <= 19'h00000;
      clk_d <= 1'b0;
    end else begin
      lnk_s1 <= {lnk.lnk_clk, lnk.req, lnk.wr, lnk.addr, lnk.wdata};
      lnk_s2 <= lnk_s1;
      clk_d <= s_clk;
    end
  end
  assign {s_clk, s_req, s_wr, s_addr, s_wdata} = lnk_s2;
  assign rise = s_clk & ~clk_d;
  assign acc = rise & s_req & ~served;
  assign do_wr = acc & s_wr;
  assign wr_ok = do_wr & ~wr_err;
  assign pre_idx = s_addr - `ECFF_OFS_PRE;
  assign max_idx = s_addr - `ECFF_OFS_MAX;
  // one access per request, rearmed when request drops
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      served <= 1'b0;
    end else if (!s_req) begin
      served <= 1'b0;
    end else if (acc) begin
      served <= 1'b1;
    end
  end
  // read mux and switch error decode
  always_comb begin
    rd_byte = `ECFF_ZERO8;
    wr_err = 1'b0;
    pre_new = preload;
    pre_new[{pre_idx[1:0], 3'b000} +: 8] = s_wdata;
    psa_bad = s_wdata[`ECFF_PSA_EN_BIT] & (s_wdata[`ECFF_PSA_MODE_BIT] ?
      ~PSA_CAPS[`ECFF_PSA_CAP_AUTO] : ~PSA_CAPS[`ECFF_PSA_CAP_MAN]);
    if (pre_idx < `ECFF_WIDE_BYTES) begin
      rd_byte = preload[{pre_idx[1:0], 3'b000} +: 8];
      wr_err = pre_new > MAX_PRELOAD;
    end else if (max_idx < `ECFF_WIDE_BYTES) begin
      rd_byte = MAX_PRELOAD[{max_idx[1:0], 3'b000} +: 8];
      wr_err = 1'b1;
    end else begin
      case (s_addr)
        `ECFF_OFS_BARRIER: rd_byte[`ECFF_EN_BIT] = o_barrier_en;
        `ECFF_OFS_MODE: begin
          rd_byte = mode_sel;
          wr_err = (s_wdata != `ECFF_MODE_NORMAL)
            & (s_wdata != `ECFF_MODE_UPDATE)
            & (s_wdata != `ECFF_MODE_VENDOR);
        end
        `ECFF_OFS_OPC: begin
          rd_byte = op_code;
          wr_err = ~o_upd_mode | ((s_wdata != `ECFF_OP_INSTALL)
            & (s_wdata != `ECFF_OP_ABORT));
        end
        `ECFF_OFS_FWRES: begin
          rd_byte = fw_result;
          wr_err = 1'b1;
        end
        `ECFF_OFS_PSA: begin
          rd_byte[1:0] = PSA_CAPS;
          rd_byte[`ECFF_PSA_EN_BIT] = o_psa_en;
          rd_byte[`ECFF_PSA_MODE_BIT] = psa_mode;
          wr_err = psa_bad;
        end
        `ECFF_OFS_REMOVAL: begin
          rd_byte[3:0] = RM_CAPS;
          rd_byte[`ECFF_RM_CFG_LSB +: 2] = o_removal_method;
        end
        `ECFF_OFS_CMDQ: rd_byte[`ECFF_EN_BIT] = o_cmdq_en;
        default: wr_err = 1'b1;
      endcase
    end
  end
  // response toggles once per served request
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      lnk.rsp_tog <= 1'b0;
      lnk.rsp_rdata <= `ECFF_ZERO8;
      lnk.rsp_err <= 1'b0;
      o_switch_err <= 1'b0;
    end else begin
      o_switch_err <= do_wr & wr_err;
      if (acc) begin
        lnk.rsp_tog <= ~lnk.rsp_tog;
        lnk.rsp_rdata <= rd_byte;
        lnk.rsp_err <= s_wr & wr_err;
      end
    end
  end
  // barrier and command queue enables
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_barrier_en <= 1'b0;
      o_cmdq_en <= 1'b0;
    end else if (wr_ok && s_addr == `ECFF_OFS_BARRIER) begin
      o_barrier_en <= s_wdata[`ECFF_EN_BIT];
    end else if (wr_ok && s_addr == `ECFF_OFS_CMDQ) begin
      o_cmdq_en <= s_wdata[`ECFF_EN_BIT];
    end
  end
  // mode select and update operations
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mode_sel <= `ECFF_MODE_NORMAL;
      o_upd_mode <= 1'b0;
      o_vendor_mode <= 1'b0;
      op_code <= `ECFF_ZERO8;
      o_fw_install <= 1'b0;
      o_fw_abort <= 1'b0;
    end else begin
      o_fw_install <= wr_ok & (s_addr == `ECFF_OFS_OPC)
        & (s_wdata == `ECFF_OP_INSTALL);
      o_fw_abort <= wr_ok & (s_addr == `ECFF_OFS_OPC)
        & (s_wdata == `ECFF_OP_ABORT);
      if (wr_ok && s_addr == `ECFF_OFS_MODE) begin
        mode_sel <= s_wdata;
        o_upd_mode <= s_wdata == `ECFF_MODE_UPDATE;
        o_vendor_mode <= s_wdata == `ECFF_MODE_VENDOR;
      end
      if (wr_ok && s_addr == `ECFF_OFS_OPC) begin
        op_code <= s_wdata;
      end
    end
  end
  // update result, undefined codes fold to general error
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      fw_result <= `ECFF_RES_OK;
    end else if (i_fw_result_vld) begin
      if (i_fw_result == `ECFF_RES_OK || i_fw_result == `ECFF_RES_INSTALL
        || i_fw_result == `ECFF_RES_DOWNLOAD) begin
        fw_result <= i_fw_result;
      end else begin
        fw_result <= `ECFF_RES_GENERAL;
      end
    end
  end
  // preload count, sectors or replay frames alike
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      preload <= `ECFF_ZERO32;
    end else if (wr_ok && pre_idx < `ECFF_WIDE_BYTES) begin
      preload <= pre_new;
    end
  end
  // awareness enable, set once, mode only while enabled
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_psa_en <= 1'b0;
      psa_mode <= 1'b0;
      psa_once <= 1'b0;
      o_psa_auto <= 1'b0;
    end else begin
      o_psa_auto <= o_psa_en & psa_mode;
      if (wr_ok && s_addr == `ECFF_OFS_PSA && !(s_wdata[`ECFF_PSA_EN_BIT]
        && !o_psa_en && psa_once)) begin
        o_psa_en <= s_wdata[`ECFF_PSA_EN_BIT];
        psa_mode <= s_wdata[`ECFF_PSA_MODE_BIT];
        psa_once <= psa_once | s_wdata[`ECFF_PSA_EN_BIT];
      end
    end
  end
  // removal method takes only the first write
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_removal_method <= 2'h0;
      rm_once <= 1'b0;
    end else if (wr_ok && s_addr == `ECFF_OFS_REMOVAL && !rm_once) begin
      o_removal_method <= s_wdata[`ECFF_RM_CFG_LSB +: 2];
      rm_once <= 1'b1;
    end
  end
  // random source for the last purge pass
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      lfsr <= `ECFF_LFSR_SEED;
    end else begin
      lfsr <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    end
  end

  // three pass overwrite pattern sequence
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      purge <= ecff_pkg::ECFF_PURGE_IDLE;
      o_purge_vld <= 1'b0;
      o_purge_data <= `ECFF_ZERO8;
    end else begin
      unique case (purge)
        ecff_pkg::ECFF_PURGE_IDLE: begin
          if (i_purge_start && o_removal_method == `ECFF_RM_THREE_PASS) begin
            o_purge_vld <= 1'b1;
            o_purge_data <= i_purge_char;
            purge <= ecff_pkg::ECFF_PURGE_CHAR;
          end
        end
        ecff_pkg::ECFF_PURGE_CHAR: begin
          o_purge_data <= ~o_purge_data;
          purge <= ecff_pkg::ECFF_PURGE_CPL;
        end
        ecff_pkg::ECFF_PURGE_CPL: begin
          o_purge_data <= lfsr;
          purge <= ecff_pkg::ECFF_PURGE_RAND;
        end
        ecff_pkg::ECFF_PURGE_RAND: begin
          o_purge_vld <= 1'b0;
          purge <= ecff_pkg::ECFF_PURGE_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// file: test/ecff_properties.sv
`timescale 1ns/1ps
`default_nettype none
module ecff_properties #(
  parameter logic [31:0] MAX_PRELOAD = 32'h0001_0000
) (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic lnk_clk,
  input wire logic req,
  input wire logic wr,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic rsp_tog,
  input wire logic [7:0] rsp_rdata,
  input wire logic rsp_err
);
  logic tog_q, served, bar_sh, cmdq_sh, upd_sh;
  logic done, rd_done, wr_done, max_a, pre_a;
  logic [4:0] bi;
  logic [31:0] pre_sh, pre_new;
  // answer seen, and which bytes it concerns
  assign done = rsp_tog != tog_q;
  assign rd_done = done && !wr;
  assign wr_done = done && wr;
  assign max_a = addr >= 8'h12 && addr <= 8'h15;
  assign pre_a = addr >= 8'h16 && addr <= 8'h19;
  assign bi = {addr[1:0] - 2'h2, 3'h0};
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);
  // one answer per request
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tog_q <= 1'h0;
      served <= 1'h0;
    end else begin
      tog_q <= rsp_tog;
      served <= req && (served || done);
    end
  end
  // shadows of accepted writes
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      bar_sh <= 1'h0;
      cmdq_sh <= 1'h0;
      upd_sh <= 1'h0;
      pre_sh <= 32'h0;
    end else if (wr_done && !rsp_err) begin
      if (addr == 8'h1F) bar_sh <= wdata[0];
      if (addr == 8'h0F) cmdq_sh <= wdata[0];
      if (addr == 8'h1E) upd_sh <= wdata == 8'h01;
      if (pre_a) pre_sh <= pre_new;
    end
  end
  // preload value after a byte write
  always_comb begin
    pre_new = pre_sh;
    pre_new[bi +: 8] = wdata;
  end
  property p_answer;
    $rose(lnk_clk) && req && !served |-> ##[1:8] done;
  endproperty
  a_answer: assert property (p_answer) else $error("late answer");
  property p_once;
    done |-> req && !served;
  endproperty
  a_once: assert property (p_once) else $error("stray answer");
  property p_barrier;
    rd_done && addr == 8'h1F |-> rsp_rdata == {7'h0, bar_sh};
  endproperty
  a_barrier: assert property (p_barrier) else $error("barrier byte");
  property p_cmdq;
    rd_done && addr == 8'h0F |-> rsp_rdata == {7'h0, cmdq_sh};
  endproperty
  a_cmdq: assert property (p_cmdq) else $error("queue byte");
  property p_max_rd;
    rd_done && max_a |-> rsp_rdata == MAX_PRELOAD[bi +: 8];
  endproperty
  a_max_rd: assert property (p_max_rd) else $error("max byte");
  property p_ro_wr;
    wr_done && (max_a || addr == 8'h1A) |-> rsp_err;
  endproperty
  a_ro_wr: assert property (p_ro_wr) else $error("read-only taken");
  property p_preload;
    wr_done && pre_a |-> rsp_err == (pre_new > MAX_PRELOAD);
  endproperty
  a_preload: assert property (p_preload) else $error("preload check");
  property p_op_mode;
    wr_done && addr == 8'h1D && !upd_sh |-> rsp_err;
  endproperty
  a_op_mode: assert property (p_op_mode) else $error("op outside update");
endmodule
`default_nettype wire

// file: test/ecff_test.sv
`timescale 1ns/1ps
`default_nettype none
module ecff_test;
  typedef struct packed {
    logic err;
    logic [7:0] val;
    logic [7:0] msk;
  } ecff_exp_type;
  localparam logic [31:0] MAXP = 32'h0001_0000;
  logic clk = 1'h0;
  logic rst_b = 1'h0;
  logic [3:0] av_a = 4'h0;
  logic av_rd = 1'h0;
  logic av_wr = 1'h0;
  logic [31:0] av_wd = 32'h0;
  logic [7:0] fw_res = 8'h0;
  logic fw_vld = 1'h0;
  logic pg_go = 1'h0;
  logic [7:0] pg_ch = 8'h0;
  logic [31:0] av_q, st;
  logic av_wait, bar_en, cq_en, upd, vnd, inst, abrt, psa_en, psa_auto;
  logic pg_vld, serr;
  logic [1:0] rm;
  logic [7:0] pg_d, v;
  logic [7:0] sh [2];
  logic [7:0] rc [4];
  logic tog_seen = 1'h0;
  ecff_exp_type exp_q[$];
  ecff_exp_type note;
  int n_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  int n_inst = 0;
  int n_abrt = 0;
  int n_serr = 0;
  int n_eexp = 0;
  ecff_link_if lnk ();
  ecff_host i_ecff_host (.i_clk_sys(clk), .i_rst_b(rst_b), .lnk(lnk),
    .i_avs_address(av_a), .i_avs_read(av_rd), .i_avs_write(av_wr),
    .i_avs_writedata(av_wd), .o_avs_readdata(av_q),
    .o_avs_waitrequest(av_wait));
  ecff_device #(.MAX_PRELOAD(MAXP)) i_ecff_device (.i_clk_sys(clk),
    .i_rst_b(rst_b), .lnk(lnk), .i_fw_result(fw_res),
    .i_fw_result_vld(fw_vld), .i_purge_start(pg_go), .i_purge_char(pg_ch),
    .o_barrier_en(bar_en), .o_cmdq_en(cq_en), .o_upd_mode(upd),
    .o_vendor_mode(vnd), .o_fw_install(inst), .o_fw_abort(abrt),
    .o_psa_en(psa_en), .o_psa_auto(psa_auto), .o_removal_method(rm),
    .o_purge_vld(pg_vld), .o_purge_data(pg_d), .o_switch_err(serr));
  ecff_properties #(.MAX_PRELOAD(MAXP)) i_ecff_properties (.i_clk_sys(clk),
    .i_rst_b(rst_b), .lnk_clk(lnk.lnk_clk), .req(lnk.req), .wr(lnk.wr),
    .addr(lnk.addr), .wdata(lnk.wdata), .rsp_tog(lnk.rsp_tog),
    .rsp_rdata(lnk.rsp_rdata), .rsp_err(lnk.rsp_err));
  // system clock
  initial begin
    forever #2.5 clk = ~clk;
  end
  task automatic stop_test();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string w, input logic [15:0] e,
      input logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", w, e, g);
    end
  endtask
  // one bus access, held until waitrequest is seen low
  task automatic acc(input logic rd, input logic [3:0] a,
      input logic [31:0] d);
    @(posedge clk);
    av_a <= a;
    av_rd <= rd;
    av_wr <= !rd;
    av_wd <= d;
    do @(posedge clk); while (av_wait !== 1'h0);
    st = av_q;
    av_rd <= 1'h0;
    av_wr <= 1'h0;
  endtask
  task automatic send(input logic w, input logic [7:0] a,
      input logic [7:0] d);
    acc(1'h0, 4'h0, {15'h0, w, a, d});
    st = 32'h1;
    while (st[0] !== 1'h0) acc(1'h1, 4'h4, 32'h0);
  endtask
  task automatic op(input logic w, input logic [7:0] a, input logic [7:0] d,
      input logic [7:0] e, input logic er, input logic [7:0] m);
    exp_q.push_back({er, e, m});
    if (er) n_eexp++;
    send(w, a, d);
    chk("status", {e & m, 6'h0, er, 1'h0}, {st[15:8] & m, 6'h0, st[1:0]});
  endtask
  task automatic refd(input logic [7:0] a, input logic [7:0] d);
    send(1'h1, a, d);
    chk("refused flag", 16'h1, {15'h0, st[2]});
  endtask
  // link answers against the oldest note
  always @(posedge clk) begin
    if (rst_b && lnk.rsp_tog !== tog_seen) begin
      note = exp_q.pop_front();
      chk("link byte", {8'h0, note.val & note.msk},
        {8'h0, lnk.rsp_rdata & note.msk});
      chk("link error", {15'h0, note.err}, {15'h0, lnk.rsp_err});
    end
    tog_seen = lnk.rsp_tog;
  end
  // pulse tallies and hang guard
  always @(posedge clk) begin
    if (inst === 1'h1) n_inst++;
    if (abrt === 1'h1) n_abrt++;
    if (serr === 1'h1) n_serr++;
    cycles++;
    if (cycles == 30000) begin
      n_errors++;
      $display("ERROR timeout expected done seen %0d cycles", cycles);
      stop_test();
    end
  end
  // main sequence
  initial begin
    void'($urandom(32'hDB515C55));
    rc = '{8'h00, 8'h10, 8'h11, 8'h12};
    sh = '{8'h00, 8'h00};
    repeat (2) @(posedge clk);
    rst_b <= 1'h1;
    for (int i = 0; i < 6; i++) begin
      v = 8'($urandom);
      op(1'h1, i[0] ? 8'h0F : 8'h1F, v, sh[i[0]], 1'h0, 8'hFF);
      sh[i[0]] = {7'h0, v[0]};
      op(1'h0, i[0] ? 8'h0F : 8'h1F, 8'h00, sh[i[0]], 1'h0, 8'hFF);
      chk("enable", {15'h0, v[0]}, {15'h0, i[0] ? cq_en : bar_en});
    end
    refd(8'h1E, 8'h02);
    op(1'h1, 8'h1E, 8'h01, 8'h00, 1'h0, 8'hFF);
    chk("update mode", 16'h2, {14'h0, upd, vnd});
    op(1'h1, 8'h1D, 8'h01, 8'h00, 1'h0, 8'hFF);
    op(1'h1, 8'h1D, 8'h02, 8'h01, 1'h0, 8'hFF);
    refd(8'h1D, 8'h03);
    op(1'h1, 8'h1E, 8'h10, 8'h01, 1'h0, 8'hFF);
    chk("vendor mode", 16'h1, {14'h0, upd, vnd});
    op(1'h1, 8'h1D, 8'h01, 8'h02, 1'h1, 8'hFF);
    op(1'h1, 8'h1E, 8'h00, 8'h10, 1'h0, 8'hFF);
    chk("normal mode", 16'h0, {14'h0, upd, vnd});
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      fw_res <= rc[i];
      fw_vld <= 1'h1;
      @(posedge clk);
      fw_vld <= 1'h0;
      op(1'h0, 8'h1A, 8'h00, rc[i], 1'h0, 8'hFF);
      op(1'h1, 8'h1A, 8'($urandom), rc[i], 1'h1, 8'hFF);
    end
    for (int i = 0; i < 4; i++) begin
      op(1'h0, 8'h12 + 8'(i), 8'h00, MAXP[8*i +: 8], 1'h0, 8'hFF);
    end
    op(1'h1, 8'h12, 8'hFF, MAXP[7:0], 1'h1, 8'hFF);
    op(1'h1, 8'h16, 8'hFF, 8'h00, 1'h0, 8'hFF);
    op(1'h1, 8'h18, 8'h02, 8'h00, 1'h1, 8'hFF);
    op(1'h0, 8'h18, 8'h00, 8'h00, 1'h0, 8'hFF);
    op(1'h0, 8'h16, 8'h00, 8'hFF, 1'h0, 8'hFF);
    op(1'h1, 8'h11, 8'h20, 8'h03, 1'h0, 8'hFF);
    chk("awareness idle", 16'h0, {14'h0, psa_en, psa_auto});
    op(1'h1, 8'h11, 8'h30, 8'h03, 1'h0, 8'hDF);
    chk("awareness auto", 16'h3, {14'h0, psa_en, psa_auto});
    op(1'h1, 8'h11, 8'h00, 8'h13, 1'h0, 8'hDF);
    op(1'h1, 8'h11, 8'h10, 8'h03, 1'h0, 8'hDF);
    chk("awareness once", 16'h0, {14'h0, psa_en, psa_auto});
    refd(8'h11, 8'hC0);
    op(1'h0, 8'h10, 8'h00, 8'h0F, 1'h0, 8'hFF);
    op(1'h1, 8'h10, 8'h2F, 8'h0F, 1'h0, 8'hFF);
    refd(8'h10, 8'h10);
    chk("removal method", 16'h2, {14'h0, rm});
    v = 8'($urandom);
    @(posedge clk);
    pg_ch <= v;
    pg_go <= 1'h1;
    @(posedge clk);
    pg_go <= 1'h0;
    for (int k = 0; k < 20 && pg_vld !== 1'h1; k++) @(posedge clk);
    chk("purge first", {7'h0, 1'h1, v}, {7'h0, pg_vld, pg_d});
    @(posedge clk);
    chk("purge second", {7'h0, 1'h1, ~v}, {7'h0, pg_vld, pg_d});
    @(posedge clk);
    chk("purge third", 16'h1, {15'h0, pg_vld});
    @(posedge clk);
    chk("purge end", 16'h0, {15'h0, pg_vld});
    op(1'h1, 8'h00, 8'h5A, 8'h00, 1'h1, 8'h00);
    acc(1'h1, 4'h8, 32'h0);
    chk("unmapped bus read", 16'h0, st[15:0]);
    // last taken command echoes: write bit, offset 0x00, data 0x5A
    acc(1'h1, 4'h0, 32'h0);
    chk("command echo", 16'h805A, {st[16], st[14:0]});
    chk("switch errors", 16'(n_eexp), 16'(n_serr));
    chk("install pulses", 16'h1, 16'(n_inst));
    chk("abort pulses", 16'h1, 16'(n_abrt));
    chk("pending notes", 16'h0, 16'(exp_q.size()));
    stop_test();
  end
endmodule
`default_nettype wire
